// ===== addr_gen_pkg.sv
// Constants, types and encodings shared by the operand and address generation logic.
// Assumes a single 50 MHz core clock and a decoder that presents one decoded operand at a time.
// Contract
// [RL1] An instruction carries zero to three operands, each from a register, an immediate or memory.
// [RL2] Operands are 8 or 32 bits in 32-bit code and 8 or 16 bits in 16-bit code unless overridden.
// [RL3] The core holds a 32-byte queue of prefetched instruction bytes ahead of decode.
// [RL4] A register operand comes from an 8, 16 or 32-bit register; an immediate comes from the code bytes.
// [RL5] The linear address of a memory operand is segment base plus effective address.
// [RL6] The effective address is base plus scaled index plus displacement, any part possibly absent.
// [RL7] The index is multiplied by 1, 2, 4 or 8 before it is added.
// [RL8] Any register may be the base; any register but the stack pointer may be the index.
// [RL9] Address calculation costs no extra cycle except one more when base and index are both used.
// [RL10] In direct mode the offset is only the 8, 16 or 32-bit displacement.
// [RL11] A default-size flag of 0 gives 16-bit defaults and 1 gives 32-bit defaults.
// [RL12] In real mode the defaults are 16 bits whatever the descriptor says.
// [RL13] Operand-size and address-length prefixes each invert the default for one instruction.
// [RL14] In real mode an address above ffff raises a protection fault even with a prefix.
// [RL15] In real mode the address prefix only enables extra modes and never reaches past 64 Kbytes.
// [RL16] In 32-bit code displacements are 8 or 32 bits and every register may be base or index; the code never takes the stack pointer as index.
// [RL17] In 16-bit code displacements are 8 or 16 bits and registers follow the legacy 16-bit pairs.
package addr_gen_pkg;

  localparam int QUEUE_BYTES = 32;
  localparam int MAX_OPERANDS = 3;
  localparam logic [2:0] STACK_PTR_IDX = 3'h4;
  localparam logic [31:0] REAL_LIMIT = 32'h0000ffff;
  localparam logic [31:0] CLEAR_VALUE = 32'h00000000;

  // Operand source.
  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_REG = 2'h1,
    SRC_IMM = 2'h2,
    SRC_MEM = 2'h3
  } src_t;

  // Operand width as delivered.
  typedef enum logic [1:0] {
    W8 = 2'h0,
    W16 = 2'h1,
    W32 = 2'h2
  } width_t;

  // Displacement width in the code bytes.
  typedef enum logic [1:0] {
    DISP_NONE = 2'h0,
    DISP_8 = 2'h1,
    DISP_WIDE = 2'h2
  } disp_t;

  // One-hot pipeline states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SUM = 3'b010,
    ST_OUT = 3'b100
  } state_t;

  // One decoded operand request.
  typedef struct packed {
    src_t src;
    logic byte_op;
    logic has_base;
    logic [2:0] base_sel;
    logic has_index;
    logic [2:0] index_sel;
    logic [1:0] scale_log2;
    disp_t disp_kind;
    logic [31:0] disp;
    logic [31:0] imm;
    logic [2:0] reg_sel;
    logic [31:0] seg_base;
  } req_t;

  // Result of one operand.
  typedef struct packed {
    src_t src;
    width_t width;
    logic addr32;
    logic [31:0] value;
    logic [31:0] eff_addr;
    logic [31:0] linear;
    logic gp_fault;
  } res_t;

endpackage

// ===== operand_address_generation.sv
// Operand width selection and effective and linear address generation.
// Assumes the register file is read combinationally through the reg_file port.
`timescale 1ns/1ps
module operand_address_generation #(
  parameter int QUEUE_BYTES = addr_gen_pkg::QUEUE_BYTES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic default_size_flag,
  input wire logic real_mode,
  input wire logic opsize_prefix,
  input wire logic addrlen_prefix,
  input wire logic [1:0] operand_count,
  input wire logic req_valid,
  input wire addr_gen_pkg::req_t req,
  input wire logic [255:0] reg_file,
  input wire logic fetch_valid,
  input wire logic [7:0] fetch_byte,
  input wire logic queue_pop,
  output logic busy_q,
  output logic res_valid_q,
  output addr_gen_pkg::res_t res_q,
  output logic queue_full_q,
  output logic [7:0] queue_head_q,
  output logic queue_has_data_q
);

  addr_gen_pkg::state_t state_q;
  addr_gen_pkg::req_t held_q;
  logic op32_q;
  logic ad32_q;
  logic [31:0] part_q;
  logic [31:0] eff_addr_d;
  logic op32_d;
  logic ad32_d;
  logic [31:0] base_v;
  logic [31:0] index_v;
  logic [31:0] scaled_v;
  logic [31:0] disp_v;
  logic [31:0] reg_v;
  logic index_ok;
  logic two_step;
  logic [7:0] queue_mem [QUEUE_BYTES];
  logic [$clog2(QUEUE_BYTES)-1:0] wr_ptr_q;
  logic [$clog2(QUEUE_BYTES)-1:0] rd_ptr_q;
  logic [$clog2(QUEUE_BYTES):0] count_q;
  logic real_q;
  logic push_ok;
  logic pop_ok;
  localparam logic [$clog2(QUEUE_BYTES):0] FULL_COUNT = QUEUE_BYTES[$clog2(QUEUE_BYTES):0];

  // Default sizes: real mode forces 16 bits, otherwise the flag decides, and each prefix inverts.
  always_comb begin
    op32_d = default_size_flag & ~real_mode; // RL11 RL12
    ad32_d = default_size_flag & ~real_mode; // RL11 RL12
    op32_d = op32_d ^ opsize_prefix; // RL13
    ad32_d = ad32_d ^ addrlen_prefix; // RL13 RL15
  end

  // Component fetch; the stack pointer is never a valid index, so it is read as absent.
  always_comb begin
    base_v = held_q.has_base ? reg_file[held_q.base_sel*32 +: 32] : 32'h0; // RL8
    index_ok = held_q.has_index && (held_q.index_sel != addr_gen_pkg::STACK_PTR_IDX); // RL8
    index_v = index_ok ? reg_file[held_q.index_sel*32 +: 32] : 32'h0;
    scaled_v = index_v << held_q.scale_log2; // RL7
    case (held_q.disp_kind)
      addr_gen_pkg::DISP_8: disp_v = {{24{held_q.disp[7]}}, held_q.disp[7:0]};
      addr_gen_pkg::DISP_WIDE: disp_v = ad32_q ? held_q.disp : // RL16
        {{16{held_q.disp[15]}}, held_q.disp[15:0]}; // RL17
      default: disp_v = 32'h0; // RL10
    endcase
    if (!ad32_q) begin
      base_v = {16'h0, base_v[15:0]}; // RL17
      scaled_v = {16'h0, scaled_v[15:0]};
    end
    // Only a memory operand pays the extra clock; other sources never use the address.
    two_step = (held_q.src == addr_gen_pkg::SRC_MEM) && held_q.has_base && index_ok;
  end

  // Effective address; with base and index both present the base sum was taken a cycle earlier.
  always_comb begin
    if (two_step) begin
      eff_addr_d = part_q + disp_v; // RL9
    end else begin
      eff_addr_d = base_v + scaled_v + disp_v; // RL6 RL10
    end
    if (!ad32_q) begin
      eff_addr_d = {16'h0, eff_addr_d[15:0]};
    end
  end

  // Register operand value, narrowed to the chosen width.
  always_comb begin
    reg_v = reg_file[held_q.reg_sel*32 +: 32]; // RL4
    if (held_q.byte_op) begin
      reg_v = {24'h0, reg_v[7:0]};
    end else if (!op32_q) begin
      reg_v = {16'h0, reg_v[15:0]};
    end
  end

  // Sequencer: a request is taken in idle and answered one or two cycles later.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= addr_gen_pkg::ST_IDLE;
      held_q <= '0;
      op32_q <= 1'b0;
      ad32_q <= 1'b0;
      part_q <= addr_gen_pkg::CLEAR_VALUE;
      real_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      case (state_q)
        addr_gen_pkg::ST_IDLE: begin
          if (req_valid && operand_count != 2'h0) begin // RL1
            held_q <= req;
            op32_q <= op32_d;
            ad32_q <= ad32_d;
            real_q <= real_mode; // RL14
            state_q <= addr_gen_pkg::ST_SUM;
            busy_q <= 1'b1;
          end
        end
        addr_gen_pkg::ST_SUM: begin
          part_q <= base_v + scaled_v;
          if (two_step && held_q.src == addr_gen_pkg::SRC_MEM) begin
            state_q <= addr_gen_pkg::ST_OUT; // RL9
          end else begin
            state_q <= addr_gen_pkg::ST_IDLE;
            busy_q <= 1'b0;
          end
        end
        addr_gen_pkg::ST_OUT: begin
          state_q <= addr_gen_pkg::ST_IDLE;
          busy_q <= 1'b0;
        end
        default: begin
          state_q <= addr_gen_pkg::ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // Result register, loaded in the cycle the answer is ready.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      res_valid_q <= 1'b0;
      res_q <= '0;
    end else begin
      res_valid_q <= 1'b0;
      if ((state_q == addr_gen_pkg::ST_SUM &&
           !(two_step && held_q.src == addr_gen_pkg::SRC_MEM)) ||
          state_q == addr_gen_pkg::ST_OUT) begin
        res_valid_q <= 1'b1;
        res_q.src <= held_q.src; // RL1
        res_q.width <= held_q.byte_op ? addr_gen_pkg::W8 :
          (op32_q ? addr_gen_pkg::W32 : addr_gen_pkg::W16); // RL2
        res_q.addr32 <= ad32_q;
        res_q.eff_addr <= eff_addr_d;
        res_q.linear <= held_q.seg_base + eff_addr_d; // RL5
        // Only a 32-bit offset can pass ffff; a 16-bit offset wraps inside the segment.
        res_q.gp_fault <= (held_q.src == addr_gen_pkg::SRC_MEM) && real_q &&
          (eff_addr_d > addr_gen_pkg::REAL_LIMIT); // RL14 RL15
        case (held_q.src)
          addr_gen_pkg::SRC_REG: res_q.value <= reg_v; // RL4
          addr_gen_pkg::SRC_IMM: res_q.value <= held_q.imm; // RL4
          default: res_q.value <= addr_gen_pkg::CLEAR_VALUE;
        endcase
      end
    end
  end

  // Push and pop are gated on the live count: the registered flags lag a cycle and
  // would let one byte too many in, or pop an empty queue.
  always_comb begin
    push_ok = fetch_valid && (count_q != FULL_COUNT); // RL3
    pop_ok = queue_pop && (count_q != '0);
  end

  // Instruction byte queue; a full queue drops further fetch bytes, so the prefetcher watches full.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push_ok) begin
        wr_ptr_q <= wr_ptr_q + 1'b1; // RL3
      end
      if (pop_ok) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (push_ok ? 1'b1 : 1'b0)
        - (pop_ok ? 1'b1 : 1'b0);
    end
  end

  // Storage has no reset; the head register samples it even while the queue is empty.
  always_ff @(posedge clk) begin
    if (push_ok) begin
      queue_mem[wr_ptr_q] <= fetch_byte; // RL3
    end
  end

  // Registered queue status and head byte.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      queue_full_q <= 1'b0;
      queue_has_data_q <= 1'b0;
      queue_head_q <= 8'h00;
    end else begin
      queue_full_q <= (count_q == QUEUE_BYTES[$clog2(QUEUE_BYTES):0]);
      queue_has_data_q <= (count_q != '0);
      queue_head_q <= queue_mem[rd_ptr_q];
    end
  end

  // Checks.
  sequence take_pair_s;
    state_q == addr_gen_pkg::ST_SUM && two_step && held_q.src == addr_gen_pkg::SRC_MEM;
  endsequence

  extra_clock_a: assert property (@(posedge clk) disable iff (rst) // RL9
    take_pair_s |=> !res_valid_q ##1 res_valid_q)
    else $error("Base plus index did not take exactly one extra clock.");

  single_clock_a: assert property (@(posedge clk) disable iff (rst) // RL9
    (state_q == addr_gen_pkg::ST_SUM && !two_step) |=> res_valid_q)
    else $error("Simple address took an extra clock.");

  linear_sum_a: assert property (@(posedge clk) disable iff (rst) // RL5
    res_valid_q |-> res_q.linear == held_q.seg_base + res_q.eff_addr)
    else $error("Linear address is not segment base plus effective address.");

  real_size_a: assert property (@(posedge clk) disable iff (rst) // RL12
    (state_q == addr_gen_pkg::ST_IDLE && req_valid && real_mode && !opsize_prefix &&
     operand_count != 2'h0) |=> !op32_q)
    else $error("Real mode default was not 16 bits.");

  prefix_invert_a: assert property (@(posedge clk) disable iff (rst) // RL13
    (state_q == addr_gen_pkg::ST_IDLE && req_valid && operand_count != 2'h0) |=>
    ad32_q == ((default_size_flag & ~real_mode) ^ addrlen_prefix))
    else $error("Address length prefix did not invert the default.");

  real_limit_a: assert property (@(posedge clk) disable iff (rst) // RL14
    (res_valid_q && res_q.src == addr_gen_pkg::SRC_MEM && real_q &&
     res_q.eff_addr > addr_gen_pkg::REAL_LIMIT) |-> res_q.gp_fault)
    else $error("Real mode address above limit without fault.");

  width_legal_a: assert property (@(posedge clk) disable iff (rst) // RL2
    res_valid_q && !res_q.addr32 && !op32_q |-> res_q.width != addr_gen_pkg::W32)
    else $error("16-bit operand reported as 32 bits.");

  queue_bound_a: assert property (@(posedge clk) disable iff (rst) // RL3
    count_q <= QUEUE_BYTES[$clog2(QUEUE_BYTES):0])
    else $error("Instruction queue overfilled.");

  // Request acceptance, the first step of every operand.
  sequence take_s;
    state_q == addr_gen_pkg::ST_IDLE && req_valid && operand_count != 2'h0;
  endsequence

  // The single computation step of an address without a base and index pair.
  sequence answer_s;
    state_q == addr_gen_pkg::ST_SUM && !two_step;
  endsequence

  // Handshake timing, refusal and sizing.
  busy_after_take_a: assert property (@(posedge clk) disable iff (rst) // RL9
    take_s |=> busy_q && !res_valid_q)
    else $error("Busy did not rise after a request was taken.");

  answer_step_a: assert property (@(posedge clk) disable iff (rst) // RL9
    answer_s |=> res_valid_q && !busy_q)
    else $error("Single-step answer missing or busy still high.");

  result_pulse_a: assert property (@(posedge clk) disable iff (rst) // RL9
    res_valid_q |=> !res_valid_q)
    else $error("Result valid stood longer than one cycle.");

  busy_refuse_a: assert property (@(posedge clk) disable iff (rst) // RL1
    (busy_q && req_valid) |=> $stable(held_q))
    else $error("A request was taken while busy.");

  zero_ops_a: assert property (@(posedge clk) disable iff (rst) // RL1
    (state_q == addr_gen_pkg::ST_IDLE && req_valid && operand_count == 2'h0) |=> !busy_q)
    else $error("A request with no operands was taken.");

  op_default_a: assert property (@(posedge clk) disable iff (rst) // RL11
    take_s ##0 (!real_mode && !opsize_prefix) |=> op32_q == $past(default_size_flag))
    else $error("Operand default did not follow the default-size flag.");

  addr_real_a: assert property (@(posedge clk) disable iff (rst) // RL12
    take_s ##0 (real_mode && !addrlen_prefix) |=> !ad32_q)
    else $error("Real mode address default was not 16 bits.");

  op_prefix_a: assert property (@(posedge clk) disable iff (rst) // RL13
    take_s ##0 opsize_prefix |=> op32_q != ($past(default_size_flag) && !$past(real_mode)))
    else $error("Operand-size prefix did not invert the default.");

  // Address components.
  sp_index_a: assert property (@(posedge clk) disable iff (rst) // RL8
    (state_q != addr_gen_pkg::ST_IDLE && held_q.has_index &&
     held_q.index_sel == addr_gen_pkg::STACK_PTR_IDX) |-> !two_step && index_v == 32'h0)
    else $error("The stack pointer was used as an index.");

  scaled_index_a: assert property (@(posedge clk) disable iff (rst) // RL7
    (state_q != addr_gen_pkg::ST_IDLE && ad32_q && index_ok) |->
    scaled_v == index_v * (32'h1 << held_q.scale_log2))
    else $error("Index was not multiplied by the scale factor.");

  pair_sum_a: assert property (@(posedge clk) disable iff (rst) // RL6
    (state_q == addr_gen_pkg::ST_OUT && ad32_q) |->
    eff_addr_d == base_v + scaled_v + disp_v)
    else $error("Two-step address differs from base plus scaled index plus displacement.");

  direct_disp_a: assert property (@(posedge clk) disable iff (rst) // RL10
    (state_q != addr_gen_pkg::ST_IDLE && !held_q.has_base && !held_q.has_index &&
     held_q.disp_kind == addr_gen_pkg::DISP_8) |-> eff_addr_d[7:0] == held_q.disp[7:0])
    else $error("Direct offset is not the displacement.");

  offset_wrap_a: assert property (@(posedge clk) disable iff (rst) // RL17
    (state_q != addr_gen_pkg::ST_IDLE && !ad32_q) |-> eff_addr_d[31:16] == 16'h0)
    else $error("A 16-bit effective address carried upper bits.");

  disp_extend_a: assert property (@(posedge clk) disable iff (rst) // RL17
    (state_q != addr_gen_pkg::ST_IDLE && !ad32_q &&
     held_q.disp_kind == addr_gen_pkg::DISP_WIDE) |-> disp_v[31:16] == {16{held_q.disp[15]}})
    else $error("A 16-bit displacement was not sign-extended.");

  // Results and faults.
  fault_mode_a: assert property (@(posedge clk) disable iff (rst) // RL14
    res_valid_q && !real_q |-> !res_q.gp_fault)
    else $error("Protection fault raised outside real mode.");

  fault_source_a: assert property (@(posedge clk) disable iff (rst) // RL14
    res_valid_q && res_q.src != addr_gen_pkg::SRC_MEM |-> !res_q.gp_fault)
    else $error("Protection fault raised for an operand not in memory.");

  byte_width_a: assert property (@(posedge clk) disable iff (rst) // RL2
    res_valid_q && held_q.byte_op |-> res_q.width == addr_gen_pkg::W8)
    else $error("Byte operand not reported as 8 bits.");

  reg_narrow_a: assert property (@(posedge clk) disable iff (rst) // RL4
    res_valid_q && res_q.src == addr_gen_pkg::SRC_REG && res_q.width == addr_gen_pkg::W16
    |-> res_q.value[31:16] == 16'h0)
    else $error("16-bit register operand carried upper bits.");

  // Queue bounds.
  queue_hold_a: assert property (@(posedge clk) disable iff (rst) // RL3
    (count_q == FULL_COUNT && !queue_pop) |=> count_q == FULL_COUNT)
    else $error("A byte was pushed into a full queue.");

  queue_empty_a: assert property (@(posedge clk) disable iff (rst) // RL3
    (count_q == '0 && !fetch_valid) |=> count_q == '0)
    else $error("A byte was popped from an empty queue.");

  full_flag_a: assert property (@(posedge clk) disable iff (rst) // RL3
    count_q == FULL_COUNT |=> queue_full_q)
    else $error("Full flag did not follow a full queue.");

endmodule // operand_address_generation

// ===== tb.sv
// Self-checking bench for operand width selection and address generation.
// Assumes the design package is compiled first and all inputs are driven at falling edges.
`timescale 1ns/1ps
module tb;
  logic clk, rst, dsf, rm, opp, alp, rv, fv, qp;
  logic [1:0] oc;
  addr_gen_pkg::req_t r;
  logic [255:0] rf;
  logic [7:0] fb;
  logic busy_q, res_valid_q, queue_full_q, queue_has_data_q;
  logic [7:0] queue_head_q;
  addr_gen_pkg::res_t res_q;
  int n_errors = 0;
  int n_checks = 0;

  operand_address_generation uut (.clk(clk), .rst(rst), .default_size_flag(dsf),
    .real_mode(rm), .opsize_prefix(opp), .addrlen_prefix(alp), .operand_count(oc),
    .req_valid(rv), .req(r), .reg_file(rf), .fetch_valid(fv), .fetch_byte(fb),
    .queue_pop(qp), .busy_q(busy_q), .res_valid_q(res_valid_q), .res_q(res_q),
    .queue_full_q(queue_full_q), .queue_head_q(queue_head_q),
    .queue_has_data_q(queue_has_data_q));

  // Register n holds (n + 1) * 01000010, so every register differs.
  function automatic logic [31:0] regv(input int n);
    return 32'h01000010 * (n + 1);
  endfunction

  task automatic summarize();
    if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Sends r with the given mode, waits a bounded time and checks the answer latency.
  task automatic issue(input logic d, input logic m, input logic o, input logic a, input int lat);
    int c;
    @(negedge clk);
    {dsf, rm, opp, alp} = {d, m, o, a};
    rv = 1'b1;
    oc = 2'h1;
    @(negedge clk);
    rv = 1'b0;
    c = 1;
    while (res_valid_q !== 1'b1 && c < 10) begin
      @(negedge clk);
      c++;
    end
    check("latency", c, lat);
  endtask

  task automatic t_reg_imm();
    r = '0;
    r.src = addr_gen_pkg::SRC_REG;
    r.reg_sel = 3'h3;
    issue(1'b1, 1'b0, 1'b0, 1'b0, 2);
    check("reg value", res_q.value, regv(3));
    check("reg width", res_q.width, addr_gen_pkg::W32);
    r.byte_op = 1'b1;
    issue(1'b1, 1'b0, 1'b0, 1'b0, 2);
    check("byte width", res_q.width, addr_gen_pkg::W8);
    check("byte value", res_q.value, 32'h00000040);
    r = '0;
    r.src = addr_gen_pkg::SRC_IMM;
    r.imm = 32'h89abcdef;
    issue(1'b0, 1'b0, 1'b1, 1'b0, 2);
    check("imm value", res_q.value, 32'h89abcdef);
    check("imm width", res_q.width, addr_gen_pkg::W32);
    check("imm src", res_q.src, addr_gen_pkg::SRC_IMM);
    issue(1'b1, 1'b1, 1'b0, 1'b0, 2);
    check("real width", res_q.width, addr_gen_pkg::W16);
    check("real addr", res_q.addr32, 1'b0);
  endtask

  task automatic t_mem32();
    r = '0;
    r.src = addr_gen_pkg::SRC_MEM;
    {r.has_base, r.base_sel, r.has_index, r.index_sel} = {1'b1, 3'h1, 1'b1, 3'h2};
    r.scale_log2 = 2'h3;
    r.disp_kind = addr_gen_pkg::DISP_WIDE;
    r.disp = 32'h00000100;
    r.seg_base = 32'h00010000;
    issue(1'b1, 1'b0, 1'b0, 1'b0, 3);
    check("eff addr scaled", res_q.eff_addr, regv(1) + regv(2) * 8 + 32'h100);
    check("linear", res_q.linear, regv(1) + regv(2) * 8 + 32'h10100);
    check("addr32", res_q.addr32, 1'b1);
    // The stack pointer cannot index, so the base-only latency applies.
    r.index_sel = addr_gen_pkg::STACK_PTR_IDX;
    r.disp_kind = addr_gen_pkg::DISP_8;
    r.disp = 32'h000000f0;
    issue(1'b1, 1'b0, 1'b0, 1'b0, 2);
    check("eff addr sp index", res_q.eff_addr, regv(1) - 32'h10);
    r.has_base = 1'b0;
    r.index_sel = 3'h5;
    r.scale_log2 = 2'h1;
    issue(1'b1, 1'b0, 1'b0, 1'b0, 2);
    check("eff addr index x2", res_q.eff_addr, regv(5) * 2 - 32'h10);
  endtask

  task automatic t_mem16();
    r = '0;
    r.src = addr_gen_pkg::SRC_MEM;
    {r.has_base, r.base_sel} = {1'b1, 3'h1};
    r.disp_kind = addr_gen_pkg::DISP_WIDE;
    r.disp = 32'h00008000;
    issue(1'b0, 1'b0, 1'b0, 1'b0, 2);
    check("eff addr 16", res_q.eff_addr, 32'h00008020);
    check("addr16", res_q.addr32, 1'b0);
    issue(1'b0, 1'b0, 1'b1, 1'b1, 2);
    check("both prefix addr", res_q.addr32, 1'b1);
    check("both prefix width", res_q.width, addr_gen_pkg::W32);
    issue(1'b0, 1'b0, 1'b0, 1'b0, 2);
    check("prefix one shot", res_q.addr32, 1'b0);
  endtask

  task automatic t_real_fault();
    r = '0;
    r.src = addr_gen_pkg::SRC_MEM;
    r.disp_kind = addr_gen_pkg::DISP_WIDE;
    r.disp = 32'h0000ffff;
    issue(1'b1, 1'b1, 1'b0, 1'b1, 2);
    check("direct eff addr", res_q.eff_addr, 32'h0000ffff);
    check("no fault", res_q.gp_fault, 1'b0);
    r.disp = 32'h00010000;
    issue(1'b1, 1'b1, 1'b0, 1'b1, 2);
    check("fault", res_q.gp_fault, 1'b1);
    r.disp = 32'h00000010;
    issue(1'b1, 1'b0, 1'b0, 1'b0, 2);
    check("fault clears", res_q.gp_fault, 1'b0);
    // A 16-bit offset wraps inside the segment, so it never faults.
    r.has_base = 1'b1;
    r.base_sel = 3'h1;
    r.disp = 32'h0000fff0;
    issue(1'b0, 1'b1, 1'b0, 1'b0, 2);
    check("wrap eff addr", res_q.eff_addr, 32'h00000010);
    check("wrap no fault", res_q.gp_fault, 1'b0);
    // A request with no operands must be ignored.
    @(negedge clk);
    {rv, oc} = {1'b1, 2'h0};
    @(negedge clk);
    rv = 1'b0;
    @(negedge clk);
    check("zero operands", {busy_q, res_valid_q}, 2'h0);
  endtask

  task automatic t_queue();
    for (int i = 0; i <= addr_gen_pkg::QUEUE_BYTES; i++) begin
      @(negedge clk);
      {fv, fb} = {1'b1, 8'(i)};
    end
    @(negedge clk);
    fv = 1'b0;
    @(negedge clk);
    check("full", queue_full_q, 1'b1);
    for (int i = 0; i < addr_gen_pkg::QUEUE_BYTES; i++) begin
      check("head", queue_head_q, 8'(i));
      qp = 1'b1;
      @(negedge clk);
      qp = 1'b0;
      @(negedge clk);
    end
    check("drained", {queue_has_data_q, queue_full_q}, 2'h0);
  endtask

  // Free-running core clock at 50 MHz.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Guards against a hang; the tests need well under a thousand cycles.
  initial begin
    #200000;
    n_errors++;
    summarize();
  end

  initial begin
    {rst, dsf, rm, opp, alp, rv, fv, qp, oc, fb} = '0;
    rst = 1'b1;
    r = '0;
    for (int i = 0; i < 8; i++) rf[i * 32 +: 32] = regv(i);
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_reg_imm();
    t_mem32();
    t_mem16();
    t_real_fault();
    t_queue();
    summarize();
  end
endmodule // tb
